/* File: include/acao_pkg.sv */
// package: constants and types for the analyzer calibration, alarm and output control
package acao_pkg;

    // ********************************
    // converter scaling
    // ********************************
    localparam int unsigned DAC_W       = 12;
    localparam logic [11:0] DAC_FULL    = 12'hfff;
    // current loop: 0..20 mA across full code, 4 mA live zero
    localparam logic [11:0] DAC_4MA     = 12'h333;
    localparam logic [11:0] DAC_8MA     = 12'h666;
    localparam logic [11:0] DAC_12MA    = 12'h999;
    localparam logic [11:0] DAC_16MA    = 12'hccc;
    localparam logic [11:0] DAC_20MA    = 12'hfff;
    localparam logic [11:0] DAC_SPAN_MA = 12'hccc;
    // voltage: 0..1 V across full code
    localparam logic [11:0] DAC_025V    = 12'h400;
    localparam logic [11:0] DAC_050V    = 12'h800;
    localparam logic [11:0] DAC_075V    = 12'hc00;
    localparam logic [11:0] DAC_100V    = 12'hfff;

    // ********************************
    // calibration timing
    // ********************************
    localparam int unsigned CAL_TIME_US = 1000;
    localparam int unsigned CLK_MHZ     = 125;
    localparam int unsigned CAL_CYCLES  = CAL_TIME_US * CLK_MHZ;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        ACAO_RNG_LOW,
        ACAO_RNG_MED,
        ACAO_RNG_HIGH,
        ACAO_RNG_AIRCAL
    } acao_range_t;

    typedef enum logic [1:0] {
        ACAO_VLV_SAMPLE,
        ACAO_VLV_ZERO,
        ACAO_VLV_SPAN
    } acao_valve_t;

endpackage

/* File: include/acao_alarm_if.sv */
// interface: one threshold alarm's configuration, measurement and relay drive
`timescale 1ns/100ps
`default_nettype none
interface acao_alarm_if;
    logic        enable;
    logic        high_mode;
    logic        failsafe;
    logic        latching;
    logic        ack;
    logic [11:0] threshold;
    logic [11:0] level;
    logic        sample;
    logic        tripped;
    logic        relay;

    modport ctrl (
        output enable, high_mode, failsafe, latching, ack, threshold, level, sample,
        input  tripped, relay
    );
    modport alarm (
        input  enable, high_mode, failsafe, latching, ack, threshold, level, sample,
        output tripped, relay
    );
endinterface
`default_nettype wire

/* File: core/acao_threshold_alarm.sv */
// threshold alarm: compare, latch and relay polarity for one channel
`timescale 1ns/100ps
`default_nettype none
module acao_threshold_alarm
    import acao_pkg::*;
(
    // clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    // channel
    acao_alarm_if.alarm al
);
    logic trip_ff;
    logic nxt_trip;
    logic relay_ff;
    logic nxt_relay;
    logic cond;

    always_comb begin
        cond = al.high_mode ? (al.level > al.threshold)
                            : (al.level < al.threshold);
        nxt_trip = trip_ff;
        if (!al.enable) begin
            nxt_trip = 1'b0;
        end else if (al.sample) begin
            if (cond) begin
                nxt_trip = 1'b1;
            end else if (!al.latching || al.ack) begin
                nxt_trip = 1'b0;
            end
        end else if (al.ack && !cond) begin
            nxt_trip = 1'b0;
        end
        // failsafe coil is energised while healthy, dropping out on alarm
        nxt_relay = al.failsafe ? !nxt_trip : nxt_trip;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            trip_ff  <= 1'b0;
            relay_ff <= 1'b0;
        end else begin
            trip_ff  <= nxt_trip;
            relay_ff <= nxt_relay;
        end
    end

    assign al.tripped = trip_ff;
    assign al.relay   = relay_ff;
endmodule
`default_nettype wire

/* File: core/acao_ctrl.sv */
// top: analog outputs, alarms and remote calibration handshake
`timescale 1ns/100ps
`default_nettype none
module acao_ctrl
    import acao_pkg::*;
#(
    parameter int unsigned CAL_LEN = CAL_CYCLES
)(
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // measurement
    input  wire logic [DAC_W-1:0]  i_conc,
    input  wire logic              i_conc_valid,
    input  wire logic [1:0]        i_range,
    // threshold alarm configuration
    input  wire logic [1:0]        i_al_enable,
    input  wire logic [1:0]        i_al_high,
    input  wire logic [1:0]        i_al_failsafe,
    input  wire logic [1:0]        i_al_latching,
    input  wire logic [1:0]        i_al_ack,
    input  wire logic [DAC_W-1:0]  i_al1_threshold,
    input  wire logic [DAC_W-1:0]  i_al2_threshold,
    // system health, from pins
    input  wire logic              i_supply_fault,
    input  wire logic              i_selftest_fail,
    // remote calibration inputs, from pins
    input  wire logic              i_remote_zero,
    input  wire logic              i_remote_span,
    input  wire logic              i_cal_done,
    input  wire logic              i_valve_option,
    // converter codes
    output logic [DAC_W-1:0]       o_volt_conc,
    output logic [DAC_W-1:0]       o_curr_conc,
    output logic [DAC_W-1:0]       o_volt_range_id,
    output logic [DAC_W-1:0]       o_curr_range_id,
    // relays and status
    output logic [1:0]             o_al_relay,
    output logic [1:0]             o_al_tripped,
    output logic                   o_sys_alarm_relay,
    output logic                   o_cal_contact,
    output logic                   o_zeroing,
    output logic                   o_spanning,
    // internal valves
    output logic                   o_valve_sample,
    output logic                   o_valve_zero,
    output logic                   o_valve_span
);
    // ********************************
    // pin synchronisers
    // ********************************
    logic [4:0] meta_ff;
    logic [4:0] sync_ff;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_ff <= 5'h00;
            sync_ff <= 5'h00;
        end else begin
            meta_ff <= {i_supply_fault, i_selftest_fail, i_remote_zero, i_remote_span,
                        i_cal_done};
            sync_ff <= meta_ff;
        end
    end
    logic s_supply;
    logic s_selftest;
    logic s_zero;
    logic s_span;
    logic s_done;
    assign s_supply   = sync_ff[4];
    assign s_selftest = sync_ff[3];
    assign s_zero     = sync_ff[2];
    assign s_span     = sync_ff[1];
    assign s_done     = sync_ff[0];

    // ********************************
    // analog output codes
    // ********************************
    logic [DAC_W-1:0] volt_ff;
    logic [DAC_W-1:0] curr_ff;
    logic [DAC_W-1:0] vid_ff;
    logic [DAC_W-1:0] cid_ff;
    logic [DAC_W-1:0] nxt_volt;
    logic [DAC_W-1:0] nxt_curr;
    logic [DAC_W-1:0] nxt_vid;
    logic [DAC_W-1:0] nxt_cid;
    logic [23:0]      scaled;

    always_comb begin
        nxt_volt = volt_ff;
        nxt_curr = curr_ff;
        // code = 4 mA + conc * 16 mA / full scale
        scaled   = 24'(i_conc) * 24'(DAC_SPAN_MA);
        if (i_conc_valid) begin
            nxt_volt = i_conc;
            nxt_curr = DAC_4MA + DAC_W'(scaled / 24'(DAC_FULL));
        end
        unique case (acao_range_t'(i_range))
            ACAO_RNG_LOW: begin
                nxt_vid = DAC_025V;
                nxt_cid = DAC_8MA;
            end
            ACAO_RNG_MED: begin
                nxt_vid = DAC_050V;
                nxt_cid = DAC_12MA;
            end
            ACAO_RNG_HIGH: begin
                nxt_vid = DAC_075V;
                nxt_cid = DAC_16MA;
            end
            ACAO_RNG_AIRCAL: begin
                nxt_vid = DAC_100V;
                nxt_cid = DAC_20MA;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            volt_ff <= 12'h000;
            curr_ff <= DAC_4MA;
            vid_ff  <= DAC_025V;
            cid_ff  <= DAC_8MA;
        end else begin
            volt_ff <= nxt_volt;
            curr_ff <= nxt_curr;
            vid_ff  <= nxt_vid;
            cid_ff  <= nxt_cid;
        end
    end
    assign o_volt_conc     = volt_ff;
    assign o_curr_conc     = curr_ff;
    assign o_volt_range_id = vid_ff;
    assign o_curr_range_id = cid_ff;

    // ********************************
    // threshold alarms
    // ********************************
    acao_alarm_if al_if[2] ();
    logic [1:0] al_relay;
    logic [1:0] al_trip;
    for (genvar g = 0; g < 2; g++) begin : g_al
        assign al_if[g].enable    = i_al_enable[g];
        assign al_if[g].high_mode = i_al_high[g];
        assign al_if[g].failsafe  = i_al_failsafe[g];
        assign al_if[g].latching  = i_al_latching[g];
        assign al_if[g].ack       = i_al_ack[g];
        assign al_if[g].threshold = (g == 0) ? i_al1_threshold : i_al2_threshold;
        assign al_if[g].level     = i_conc;
        assign al_if[g].sample    = i_conc_valid;
        assign al_relay[g]        = al_if[g].relay;
        assign al_trip[g]         = al_if[g].tripped;
        acao_threshold_alarm u_al (
            .i_clk     (i_clk),
            .i_sys_rst (i_sys_rst),
            .al        (al_if[g])
        );
    end
    assign o_al_relay   = al_relay;
    assign o_al_tripped = al_trip;

    // ********************************
    // system alarm
    // ********************************
    // only the power-on reset clears it: no software path exists
    logic sys_ff;
    logic nxt_sys;
    always_comb begin
        nxt_sys = sys_ff | s_supply | s_selftest;
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_ff <= 1'b0;
        end else begin
            sys_ff <= nxt_sys;
        end
    end
    // failsafe: coil energised while healthy
    logic sys_relay_ff;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_relay_ff <= 1'b0;
        end else begin
            sys_relay_ff <= !nxt_sys;
        end
    end
    assign o_sys_alarm_relay = sys_relay_ff;

    // ********************************
    // remote calibration sequencer
    // ********************************
    typedef enum logic [1:0] {
        ACAO_ST_ANALYSE,
        ACAO_ST_ZERO,
        ACAO_ST_SPAN
    } acao_state_t;

    acao_state_t st_ff;
    acao_state_t nxt_st;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        done_q_ff;
    logic        finish;

    // done comes from the measuring side, or from the fallback timer;
    // only its rising edge counts, so a done level left over from the
    // last run cannot cut a restarted calibration short
    assign finish = (s_done && !done_q_ff) || (cnt_ff >= CAL_LEN - 1);

    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = 32'h0;
        unique case (st_ff)
            ACAO_ST_ANALYSE: begin
                // zero wins if both are asserted together
                if (s_zero) begin
                    nxt_st = ACAO_ST_ZERO;
                end else if (s_span) begin
                    nxt_st = ACAO_ST_SPAN;
                end
            end
            ACAO_ST_ZERO: begin
                nxt_cnt = cnt_ff + 32'h1;
                if (finish) begin
                    nxt_cnt = 32'h0;
                    nxt_st  = ACAO_ST_ANALYSE;
                end
            end
            ACAO_ST_SPAN: begin
                nxt_cnt = cnt_ff + 32'h1;
                if (finish) begin
                    nxt_cnt = 32'h0;
                    nxt_st  = ACAO_ST_ANALYSE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_ff     <= ACAO_ST_ANALYSE;
            cnt_ff    <= 32'h0;
            done_q_ff <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            cnt_ff    <= nxt_cnt;
            done_q_ff <= s_done;
        end
    end

    // a held request restarts after one analysing cycle, reclosing contact
    logic cal_ff;
    logic zero_ff;
    logic span_ff;
    logic [2:0] vlv_ff;
    logic [2:0] nxt_vlv;
    always_comb begin
        nxt_vlv = 3'b100;                                        // sample flowing
        if (i_valve_option) begin
            unique case (nxt_st)
                ACAO_ST_ANALYSE: nxt_vlv = 3'b100;
                ACAO_ST_ZERO:    nxt_vlv = 3'b010;
                ACAO_ST_SPAN:    nxt_vlv = 3'b001;
            endcase
        end else begin
            nxt_vlv = 3'b000;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cal_ff  <= 1'b0;
            zero_ff <= 1'b0;
            span_ff <= 1'b0;
            vlv_ff  <= 3'b000;
        end else begin
            cal_ff  <= (nxt_st != ACAO_ST_ANALYSE);
            zero_ff <= (nxt_st == ACAO_ST_ZERO);
            span_ff <= (nxt_st == ACAO_ST_SPAN);
            vlv_ff  <= nxt_vlv;
        end
    end
    assign o_cal_contact  = cal_ff;
    assign o_zeroing      = zero_ff;
    assign o_spanning     = span_ff;
    assign o_valve_sample = vlv_ff[2];
    assign o_valve_zero   = vlv_ff[1];
    assign o_valve_span   = vlv_ff[0];
endmodule
`default_nettype wire

/* File: verification/acao_ctrl_props.sv */
// checker: concurrent properties on the control block ports
`timescale 1ns/100ps
`default_nettype none
module acao_ctrl_props
    import acao_pkg::*;
(
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    // inputs
    input wire logic [11:0] i_conc,
    input wire logic        i_conc_valid,
    input wire logic [1:0]  i_range,
    input wire logic [1:0]  i_al_enable,
    input wire logic [1:0]  i_al_high,
    input wire logic [1:0]  i_al_failsafe,
    input wire logic [11:0] i_al1_threshold,
    input wire logic        i_supply_fault,
    input wire logic        i_selftest_fail,
    input wire logic        i_remote_zero,
    input wire logic        i_valve_option,
    // outputs
    input wire logic [11:0] o_volt_conc,
    input wire logic [11:0] o_curr_conc,
    input wire logic [11:0] o_volt_range_id,
    input wire logic [11:0] o_curr_range_id,
    input wire logic [1:0]  o_al_relay,
    input wire logic [1:0]  o_al_tripped,
    input wire logic        o_sys_alarm_relay,
    input wire logic        o_cal_contact,
    input wire logic        o_zeroing,
    input wire logic        o_spanning,
    input wire logic        o_valve_sample,
    input wire logic        o_valve_zero,
    input wire logic        o_valve_span
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ****
    // properties
    // ****
    // pin must sit through both synchroniser stages with the contact open
    sequence s_zero_idle;
        $rose(i_remote_zero) && !o_cal_contact ##1 i_remote_zero && !o_cal_contact
            ##1 !o_cal_contact;
    endsequence
    a_volt_conc: assert property (i_conc_valid |=> o_volt_conc == $past(i_conc))
        else $error("voltage code wrong");
    a_curr_conc: assert property (i_conc_valid |=>
        o_curr_conc == DAC_4MA + 12'((24'($past(i_conc)) * 24'hccc) / 24'hfff))
        else $error("current code wrong");
    a_volt_id: assert property (1 |=>
        o_volt_range_id == ($past(i_range) == 2'h3 ? 12'hfff : {$past(i_range) + 2'h1, 10'h0}))
        else $error("range id wrong");
    a_curr_id: assert property (1 |=>
        o_curr_range_id == 12'h333 * ({10'h0, $past(i_range)} + 12'h2))
        else $error("current range id wrong");
    a_trip_cond: assert property (i_conc_valid && i_al_enable[0] &&
        (i_al_high[0] ? i_conc > i_al1_threshold : i_conc < i_al1_threshold) |=> o_al_tripped[0])
        else $error("alarm did not trip");
    a_relay_pol: assert property (i_conc_valid |=> o_al_relay == (o_al_tripped ^ $past(i_al_failsafe)))
        else $error("relay polarity wrong");
    a_alarm_off: assert property (1 |=> (o_al_tripped & ~$past(i_al_enable)) == 2'b00)
        else $error("disabled alarm tripped");
    a_sys_trip: assert property (i_supply_fault || i_selftest_fail |-> ##3 !o_sys_alarm_relay)
        else $error("system alarm late");
    a_sys_latch: assert property ($fell(o_sys_alarm_relay) |=> !o_sys_alarm_relay [*8])
        else $error("system alarm released");
    a_zero_start: assert property (s_zero_idle |=> o_cal_contact && o_zeroing)
        else $error("zero request not taken");
    a_contact_mode: assert property (o_cal_contact == (o_zeroing || o_spanning))
        else $error("contact disagrees with mode");
    a_valve_mode: assert property (!$past(i_sys_rst) && i_valve_option &&
        $past(i_valve_option) |-> {o_valve_sample, o_valve_zero, o_valve_span} ==
        {!o_cal_contact, o_zeroing, o_spanning})
        else $error("valves out of step");
endmodule
bind acao_ctrl acao_ctrl_props i_props (.*);
`default_nettype wire

/* File: verification/acao_remote_ctrl.sv */
// remote calibration controller model: zero, span and done pins
`timescale 1ns/100ps
`default_nettype none
module acao_remote_ctrl (
    // clock and contact
    input  wire logic i_clk,
    input  wire logic i_cal_contact,
    // request and completion pins
    output var logic  o_zero,
    output var logic  o_span,
    output var logic  o_done
);
    initial begin
        o_zero = 1'b0;
        o_span = 1'b0;
        o_done = 1'b0;
    end
    task automatic wait_contact(input logic lvl);
        int n;
        n = 0;
        while (i_cal_contact !== lvl && n < 300) begin
            @(negedge i_clk);
            n++;
        end
    endtask
    // ****
    // request cycle
    // ****
    // dly of 100 or more never signals done, so the device timer ends it
    task automatic run(input logic span, input int dly, input logic hold);
        wait_contact(1'b0);
        @(negedge i_clk);
        o_zero = !span;
        o_span = span;
        wait_contact(1'b1);
        if (!hold) begin
            o_zero = 1'b0;
            o_span = 1'b0;
        end
        repeat (dly < 100 ? dly : 0) @(negedge i_clk);
        o_done = dly < 100;
        wait_contact(1'b0);
        o_done = 1'b0;
        if (hold) begin
            wait_contact(1'b1);
            o_zero = 1'b0;
            o_span = 1'b0;
        end
    endtask
    // misbehaves on purpose: requests whatever the contact shows
    task automatic poke();
        @(negedge i_clk);
        o_span = 1'b1;
        repeat (6) @(negedge i_clk);
        o_span = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: verification/acao_ctrl_tb.sv */
// testbench: scenarios for the analyzer control block
`timescale 1ns/100ps
`default_nettype none
module acao_ctrl_tb;
    import acao_pkg::*;
    localparam int unsigned CAL_LEN = 20;
    logic        i_clk, i_sys_rst, i_conc_valid, i_supply_fault, i_selftest_fail;
    logic        i_valve_option, i_remote_zero, i_remote_span, i_cal_done;
    logic [1:0]  i_range, i_al_enable, i_al_high, i_al_failsafe, i_al_latching, i_al_ack;
    logic [11:0] i_conc, i_al1_threshold, i_al2_threshold;
    logic [11:0] o_volt_conc, o_curr_conc, o_volt_range_id, o_curr_range_id;
    logic [1:0]  o_al_relay, o_al_tripped;
    logic        o_sys_alarm_relay, o_cal_contact, o_zeroing, o_spanning;
    logic        o_valve_sample, o_valve_zero, o_valve_span;
    int          fail_count = 0;
    int          cmp_count = 0;
    acao_ctrl #(.CAL_LEN(CAL_LEN)) i_dut (.*);
    acao_remote_ctrl i_ctl (
        .i_clk         (i_clk),
        .i_cal_contact (o_cal_contact),
        .o_zero        (i_remote_zero),
        .o_span        (i_remote_span),
        .o_done        (i_cal_done)
    );
    // ****
    // helpers
    // ****
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic meas(input logic [11:0] c);
        tick(1);
        i_conc = c;
        i_conc_valid = 1'b1;
        tick(1);
        i_conc_valid = 1'b0;
        tick(1);
    endtask
    task automatic wait_c(input logic lvl);
        int n;
        n = 0;
        while (o_cal_contact !== lvl && n < 300) begin
            tick(1);
            n++;
        end
        chk({11'h0, o_cal_contact}, {11'h0, lvl});
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_out();
        logic [11:0] c;
        for (int r = 0; r < 4; r++) begin
            i_range = r[1:0];
            c = 12'h555 * r[11:0];
            meas(c);
            chk(o_volt_conc, c);
            chk(o_curr_conc, 12'h333 + 12'((24'(c) * 24'hccc) / 24'hfff));
            chk(o_volt_range_id, r == 3 ? 12'hfff : 12'h400 * 12'(r + 1));
            chk(o_curr_range_id, 12'h333 * 12'(r + 2));
        end
        $display("t_out done");
    endtask
    task automatic t_alarm();
        i_al_enable = 2'b11;
        i_al_high = 2'b01;
        i_al_failsafe = 2'b10;
        i_al_latching = 2'b01;
        i_al1_threshold = 12'h800;
        i_al2_threshold = 12'h400;
        meas(12'h900);
        chk({10'h0, o_al_tripped}, 12'h1);
        chk({10'h0, o_al_relay}, 12'h3);
        meas(12'h300);
        chk({10'h0, o_al_tripped}, 12'h3);
        chk({10'h0, o_al_relay}, 12'h1);
        meas(12'h600);
        chk({10'h0, o_al_tripped}, 12'h1);
        i_al_ack = 2'b11;
        tick(2);
        i_al_ack = 2'b00;
        tick(1);
        chk({10'h0, o_al_tripped}, 12'h0);
        i_al_enable = 2'b00;
        meas(12'hfff);
        meas(12'h000);
        chk({10'h0, o_al_tripped}, 12'h0);
        chk({10'h0, o_al_relay}, 12'h2);
        $display("t_alarm done");
    endtask
    task automatic obs(input logic s);
        wait_c(1'b1);
        chk({9'h0, o_zeroing, o_spanning, o_valve_sample}, {9'h0, !s, s, 1'b0});
        chk({10'h0, o_valve_zero, o_valve_span}, {10'h0, {!s, s} & {2{i_valve_option}}});
        wait_c(1'b0);
        chk({10'h0, o_valve_sample, o_cal_contact}, {10'h0, i_valve_option, 1'b0});
    endtask
    task automatic t_cal();
        for (int v = 0; v < 2; v++) begin
            i_valve_option = v[0];
            for (int s = 0; s < 2; s++) begin
                fork
                    i_ctl.run(s[0], 6, 1'b0);
                    obs(s[0]);
                join
            end
        end
        $display("t_cal done");
    endtask
    task automatic t_ignore();
        fork
            i_ctl.run(1'b0, 10, 1'b0);
            begin
                wait_c(1'b1);
                i_ctl.poke();
            end
        join
        tick(10);
        chk({11'h0, o_cal_contact | o_spanning}, 12'h0);
        $display("t_ignore done");
    endtask
    task automatic t_repeat();
        fork
            i_ctl.run(1'b0, 4, 1'b1);
            begin
                wait_c(1'b1);
                wait_c(1'b0);
                wait_c(1'b1);
            end
        join
        wait_c(1'b0);
        $display("t_repeat done");
    endtask
    task automatic t_timer();
        int n;
        n = 0;
        fork
            i_ctl.run(1'b1, 999, 1'b0);
            begin
                wait_c(1'b1);
                while (o_cal_contact === 1'b1 && n < 300) begin
                    tick(1);
                    n++;
                end
            end
        join
        chk({11'h0, n >= CAL_LEN - 1 && n <= CAL_LEN + 2}, 12'h1);
        $display("t_timer done");
    endtask
    task automatic t_sys();
        for (int k = 0; k < 2; k++) begin
            chk({11'h0, o_sys_alarm_relay}, 12'h1);
            {i_supply_fault, i_selftest_fail} = k[0] ? 2'b01 : 2'b10;
            tick(4);
            chk({11'h0, o_sys_alarm_relay}, 12'h0);
            {i_supply_fault, i_selftest_fail} = 2'b00;
            tick(20);
            chk({11'h0, o_sys_alarm_relay}, 12'h0);
            i_sys_rst = 1'b1;
            tick(1);
            i_sys_rst = 1'b0;
            tick(2);
        end
        chk({11'h0, o_sys_alarm_relay}, 12'h1);
        $display("t_sys done");
    endtask
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #100us;
        fail_count++;
        conclude();
    end
    initial begin
        {i_sys_rst, i_conc_valid, i_supply_fault, i_selftest_fail, i_valve_option} = 5'h10;
        {i_range, i_al_enable, i_al_high, i_al_failsafe, i_al_latching, i_al_ack} = 12'h0;
        {i_conc, i_al1_threshold, i_al2_threshold} = 36'h0;
        tick(10);
        i_sys_rst = 1'b0;
        tick(2);
        t_out();
        t_alarm();
        t_cal();
        t_ignore();
        t_repeat();
        t_timer();
        t_sys();
        conclude();
    end
endmodule
`default_nettype wire
